// ### core/sgc_top.sv
// scatter-gather command decoder with axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - enabled write loads termination select from bit7
// - disabled write keeps termination select
// - decode code bits: nop, start, stop, reserved
// - nop code still applies select programming
// - start activates and requests descriptor prefetch
// - prefetch shares the channel's request priority
// - dma request wins over prefetch in channel
// - stop halts transfer at once
// - stop sets terminate flag and channel mask
// - status register shows live transfer state
// - select 1 gives eop, 0 gives irq13
// - start clears buffers, terminate, null flag
// - command register is write only
module sgc_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // dma channel side
    input wire logic dreq,
    input wire logic pf_done,
    input wire logic buf_done,
    input wire logic last_done,
    input wire logic next_null,
    input wire logic mask_clr,
    output logic pf_gnt,
    output logic dreq_gnt,
    output logic chan_req,
    output logic chan_mask_ff,
    output logic sg_halt_ff,
    output logic eop_ff,
    output logic irq13_ff,
    output logic irq_ff
);
    typedef enum logic [1:0] {SGC_IDLE, SGC_FETCH, SGC_RUN} sgc_state_e;

    sgc_state_e state_ff;
    logic aw_ff;
    logic w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_go;
    logic cmd_wr;
    logic [1:0] code;
    logic sel_ff;
    logic active_ff;
    logic base_ff;
    logic cur_ff;
    logic term_ff;
    logic null_ff;
    logic pf_req_ff;
    logic mclr;
    logic [sgc_pkg::EV_W-1:0] ev_stat_ff;
    logic [sgc_pkg::EV_W-1:0] ev_en_ff;
    logic [sgc_pkg::EV_W-1:0] ev_set;
    logic [sgc_pkg::EV_W-1:0] ev_clr;
    logic [7:0] status;
    logic is_start;
    logic is_stop;

    // write channel capture, address and data in either order
    assign wr_go = aw_ff && w_ff && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sgc_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_ff && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ff <= 1'b0;
                w_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_ff)
                    sgc_pkg::ADDR_CMD, sgc_pkg::ADDR_EVT_EN,
                    sgc_pkg::ADDR_EVT_CLR, sgc_pkg::ADDR_CTRL:
                        s_axi_bresp <= sgc_pkg::RESP_OKAY;
                    default: s_axi_bresp <= sgc_pkg::RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // command byte is lane 0; write only, no read-back
    assign cmd_wr = wr_go && (awaddr_ff == sgc_pkg::ADDR_CMD) && wstrb_ff[0];
    assign code = wdata_ff[sgc_pkg::CMD_CODE_LO +: 2];
    assign is_start = cmd_wr && (code == sgc_pkg::CODE_START);
    assign is_stop = cmd_wr && (code == sgc_pkg::CODE_STOP);
    assign mclr = wr_go && (awaddr_ff == sgc_pkg::ADDR_CTRL) && wstrb_ff[0]
        && wdata_ff[sgc_pkg::CTRL_MCLR];

    // termination selection, any code incl. nop and reserved
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ff <= sgc_pkg::RST_SEL;
        end else if (mclr) begin
            sel_ff <= sgc_pkg::RST_SEL;
        end else if (cmd_wr && wdata_ff[sgc_pkg::CMD_PGM_BIT]) begin
            sel_ff <= wdata_ff[sgc_pkg::CMD_SEL_BIT];
        end
    end

    // scatter-gather sequencing and status
    always_ff @(posedge aclk) begin
        if (!aresetn || mclr) begin
            state_ff <= SGC_IDLE;
            active_ff <= 1'b0;
            base_ff <= 1'b0;
            cur_ff <= 1'b0;
            term_ff <= 1'b0;
            null_ff <= 1'b0;
            pf_req_ff <= 1'b0;
            sg_halt_ff <= 1'b0;
        end else if (is_stop) begin
            state_ff <= SGC_IDLE;
            active_ff <= 1'b0;
            pf_req_ff <= 1'b0;
            sg_halt_ff <= 1'b1;
            term_ff <= 1'b1;
        end else if (is_start) begin
            state_ff <= SGC_FETCH;
            pf_req_ff <= 1'b1;
            active_ff <= 1'b1;
            base_ff <= 1'b0;
            cur_ff <= 1'b0;
            term_ff <= 1'b0;
            null_ff <= 1'b0;
            sg_halt_ff <= 1'b0;
        end else begin
            case (state_ff)
                SGC_IDLE: begin
                    pf_req_ff <= 1'b0;
                end
                SGC_FETCH: begin
                    if (pf_gnt && pf_done) begin
                        pf_req_ff <= 1'b0;
                        base_ff <= 1'b1;
                        null_ff <= next_null;
                        state_ff <= SGC_RUN;
                    end
                end
                SGC_RUN: begin
                    if (dreq_gnt && base_ff && !cur_ff) begin
                        cur_ff <= 1'b1;
                        base_ff <= 1'b0;
                        pf_req_ff <= !null_ff;
                    end else if (pf_req_ff && pf_gnt && pf_done) begin
                        pf_req_ff <= 1'b0;
                        base_ff <= 1'b1;
                        null_ff <= next_null;
                    end
                    if (buf_done) begin
                        cur_ff <= 1'b0;
                    end
                    if (last_done) begin
                        active_ff <= 1'b0;
                        term_ff <= 1'b1;
                        cur_ff <= 1'b0;
                        pf_req_ff <= 1'b0;
                        state_ff <= SGC_IDLE;
                    end
                end
                default: state_ff <= SGC_IDLE;
            endcase
        end
    end

    // channel mask and termination signalling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_mask_ff <= 1'b0;
            eop_ff <= 1'b0;
            irq13_ff <= 1'b0;
        end else begin
            if (is_stop) begin
                chan_mask_ff <= 1'b1;
            end else if (mask_clr || mclr) begin
                chan_mask_ff <= 1'b0;
            end
            eop_ff <= state_ff == SGC_RUN && last_done && sel_ff;
            irq13_ff <= state_ff == SGC_RUN && last_done && !sel_ff;
        end
    end

    sgc_arb u_arb (
        .aclk(aclk),
        .aresetn(aresetn),
        .dreq(dreq && !chan_mask_ff),
        .pf_req(pf_req_ff),
        .dreq_gnt_ff(dreq_gnt),
        .pf_gnt_ff(pf_gnt),
        .chan_req_ff(chan_req)
    );

    // events: set wins over clear
    assign ev_set = {(state_ff == SGC_RUN) && last_done, is_stop, is_start};
    assign ev_clr = (wr_go && awaddr_ff == sgc_pkg::ADDR_EVT_CLR && wstrb_ff[0])
        ? wdata_ff[sgc_pkg::EV_W-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_stat_ff <= '0;
            ev_en_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            ev_stat_ff <= (ev_stat_ff & ~ev_clr) | ev_set;
            if (wr_go && awaddr_ff == sgc_pkg::ADDR_EVT_EN && wstrb_ff[0]) begin
                ev_en_ff <= wdata_ff[sgc_pkg::EV_W-1:0];
            end
            irq_ff <= |(((ev_stat_ff & ~ev_clr) | ev_set) & ev_en_ff);
        end
    end

    // live status byte
    always_comb begin
        status = 8'h00;
        status[sgc_pkg::ST_ACTIVE] = active_ff;
        status[sgc_pkg::ST_CUR] = cur_ff;
        status[sgc_pkg::ST_BASE] = base_ff;
        status[sgc_pkg::ST_TERM] = term_ff;
        status[sgc_pkg::ST_SEL] = sel_ff;
        status[sgc_pkg::ST_NULL] = null_ff;
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sgc_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= sgc_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    sgc_pkg::ADDR_STATUS: s_axi_rdata <= {24'h000000, status};
                    sgc_pkg::ADDR_EVT_STAT:
                        s_axi_rdata <= {29'h0, ev_stat_ff};
                    sgc_pkg::ADDR_EVT_EN: s_axi_rdata <= {29'h0, ev_en_ff};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= sgc_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    a_sel_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_wr && wdata_ff[sgc_pkg::CMD_PGM_BIT] && !mclr)
        |=> sel_ff == $past(wdata_ff[sgc_pkg::CMD_SEL_BIT]))
        else $error("select not loaded");
    a_sel_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_wr && !wdata_ff[sgc_pkg::CMD_PGM_BIT] && !mclr) |=> $stable(sel_ff))
        else $error("select changed without enable");
    a_nop_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        (cmd_wr && (code == sgc_pkg::CODE_NOP || code == sgc_pkg::CODE_RSVD)
        && !mclr) |=> $stable(active_ff) && $stable(chan_mask_ff))
        else $error("nop or reserved code acted");
    a_start_pf: assert property (@(posedge aclk) disable iff (!aresetn)
        (is_start && !mclr) |=> pf_req_ff && active_ff && !base_ff
        && !cur_ff && !term_ff && !null_ff)
        else $error("start state wrong");
    a_start_grant: assert property (@(posedge aclk) disable iff (!aresetn)
        (is_start && !mclr && !dreq) ##1 !dreq |=> pf_gnt)
        else $error("prefetch not granted");
    a_stop_halt: assert property (@(posedge aclk) disable iff (!aresetn)
        (is_stop && !mclr) |=> !active_ff && term_ff && chan_mask_ff
        && !pf_req_ff)
        else $error("stop did not halt");
    a_eop_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        eop_ff |-> $past(sel_ff) && !irq13_ff)
        else $error("eop with irq13 select");
    a_no_rd_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == sgc_pkg::ADDR_CMD)
        |=> s_axi_rresp == sgc_pkg::RESP_SLVERR)
        else $error("command register readable");
endmodule : sgc_top
`default_nettype wire

// ### core/sgc_pkg.sv
// package of constants for the scatter-gather command decoder
package sgc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EVT_STAT = 8'h08;
    localparam logic [7:0] ADDR_EVT_EN = 8'h0C;
    localparam logic [7:0] ADDR_EVT_CLR = 8'h10;
    localparam logic [7:0] ADDR_CTRL = 8'h14;
    // command byte fields
    localparam int CMD_SEL_BIT = 7;
    localparam int CMD_PGM_BIT = 6;
    localparam int CMD_CODE_LO = 0;
    localparam logic [1:0] CODE_NOP = 2'h0;
    localparam logic [1:0] CODE_START = 2'h1;
    localparam logic [1:0] CODE_STOP = 2'h2;
    localparam logic [1:0] CODE_RSVD = 2'h3;
    // status fields
    localparam int ST_ACTIVE = 0;
    localparam int ST_CUR = 2;
    localparam int ST_BASE = 3;
    localparam int ST_TERM = 4;
    localparam int ST_SEL = 5;
    localparam int ST_NULL = 7;
    // event bits
    localparam int EV_START = 0;
    localparam int EV_STOP = 1;
    localparam int EV_DONE = 2;
    localparam int EV_W = 3;
    // control register: bit 0 master clear (self clearing)
    localparam int CTRL_MCLR = 0;
    // reset value and response codes
    localparam logic RST_SEL = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sgc_pkg

// ### core/sgc_arb.sv
// per-channel arbitration between dma request and prefetch request
`timescale 1ns/100ps
`default_nettype none
module sgc_arb (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // requests
    input wire logic dreq,
    input wire logic pf_req,
    // grants and channel request
    output logic dreq_gnt_ff,
    output logic pf_gnt_ff,
    output logic chan_req_ff
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dreq_gnt_ff <= 1'b0;
            pf_gnt_ff <= 1'b0;
            chan_req_ff <= 1'b0;
        end else begin
            dreq_gnt_ff <= dreq;
            pf_gnt_ff <= pf_req && !dreq;
            chan_req_ff <= dreq || pf_req;
        end
    end

    a_dreq_first: assert property (@(posedge aclk) disable iff (!aresetn)
        dreq |=> !pf_gnt_ff)
        else $error("prefetch granted over dma request");
    a_same_prio: assert property (@(posedge aclk) disable iff (!aresetn)
        (pf_req && !dreq) |=> chan_req_ff && pf_gnt_ff)
        else $error("prefetch did not request arbitration");
endmodule : sgc_arb
`default_nettype wire

// ### tb/sg_command_decoder_test.sv
// self-checking bench for the scatter-gather command decoder
`timescale 1ns/100ps
`default_nettype none
module sg_command_decoder_test;
    logic aclk, aresetn;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic dreq, pf_done, buf_done, last_done, next_null, mask_clr;
    logic pf_gnt, dreq_gnt, chan_req, chan_mask_ff, sg_halt_ff;
    logic eop_ff, irq13_ff, irq_ff;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    integer seed = 88;
    logic sel;
    logic [7:0] d;

    sgc_top i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .dreq(dreq), .pf_done(pf_done),
        .buf_done(buf_done), .last_done(last_done), .next_null(next_null),
        .mask_clr(mask_clr), .pf_gnt(pf_gnt), .dreq_gnt(dreq_gnt),
        .chan_req(chan_req), .chan_mask_ff(chan_mask_ff),
        .sg_halt_ff(sg_halt_ff), .eop_ff(eop_ff), .irq13_ff(irq13_ff),
        .irq_ff(irq_ff));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : chk

    task finish_test;
        $display("checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    // write one byte to lane 0, note the expected response
    task axi_wr(input logic [7:0] a, input logic [7:0] v,
                input logic [1:0] er);
        exp_b.push_back(er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, input logic [7:0] v,
                input logic [1:0] er);
        exp_r.push_back({er, 24'h000000, v});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd

    // pulse last buffer done, see which indicator follows
    task tc_check(input logic s);
        logic e, q;
        e = 1'b0;
        q = 1'b0;
        // finish the first prefetch so the channel is running
        pf_done <= 1'b1;
        @(posedge aclk);
        pf_done <= 1'b0;
        last_done <= 1'b1;
        @(posedge aclk);
        last_done <= 1'b0;
        repeat (4) begin
            @(posedge aclk);
            e = e | eop_ff;
            q = q | irq13_ff;
        end
        chk("eop", {31'h0, s}, {31'h0, e});
        chk("irq13", {31'h0, ~s}, {31'h0, q});
    endtask : tc_check

    // compares bus answers against the oldest note
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            if (exp_b.size() == 0) chk("bresp queue", 32'h1, 32'h0);
            else chk("bresp", {30'h0, exp_b.pop_front()}, {30'h0, s_axi_bresp});
        end
        if (s_axi_rvalid && s_axi_rready) begin
            if (exp_r.size() == 0) begin
                chk("rdata queue", 32'h1, 32'h0);
            end else begin
                chk("rdata", exp_r[0][31:0], s_axi_rdata);
                chk("rresp", {30'h0, exp_r[0][33:32]}, {30'h0, s_axi_rresp});
                void'(exp_r.pop_front());
            end
        end
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        {dreq, pf_done, buf_done, last_done, next_null, mask_clr} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        sel = sgc_pkg::RST_SEL;
        axi_rd(sgc_pkg::ADDR_STATUS, 8'h00, sgc_pkg::RESP_OKAY);
        axi_rd(sgc_pkg::ADDR_CMD, 8'h00, sgc_pkg::RESP_SLVERR);
        axi_wr(8'h18, 8'h01, sgc_pkg::RESP_SLVERR);
        // select programming with no-op and reserved codes
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            d[6] = i[1];
            d[1:0] = i[0] ? sgc_pkg::CODE_RSVD : sgc_pkg::CODE_NOP;
            axi_wr(sgc_pkg::ADDR_CMD, d, sgc_pkg::RESP_OKAY);
            if (d[6]) sel = d[7];
            axi_rd(sgc_pkg::ADDR_STATUS, {2'h0, sel, 5'h00},
                   sgc_pkg::RESP_OKAY);
        end
        axi_wr(sgc_pkg::ADDR_EVT_EN, 8'h07, sgc_pkg::RESP_OKAY);
        // start with a dma request pending
        dreq <= 1'b1;
        axi_wr(sgc_pkg::ADDR_CMD, 8'h01, sgc_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("dreq_gnt", 32'h1, {31'h0, dreq_gnt});
        chk("pf_gnt held", 32'h0, {31'h0, pf_gnt});
        dreq <= 1'b0;
        for (int n = 0; n < 20 && !pf_gnt; n++) @(posedge aclk);
        chk("pf_gnt", 32'h1, {31'h0, pf_gnt});
        chk("chan_req", 32'h1, {31'h0, chan_req});
        pf_done <= 1'b1;
        next_null <= 1'b1;
        @(posedge aclk);
        pf_done <= 1'b0;
        next_null <= 1'b0;
        repeat (2) @(posedge aclk);
        axi_rd(sgc_pkg::ADDR_STATUS, {1'b1, 1'b0, sel, 5'h09},
               sgc_pkg::RESP_OKAY);
        chk("irq", 32'h1, {31'h0, irq_ff});
        // dma grant moves base to current, then current expires
        dreq <= 1'b1;
        repeat (3) @(posedge aclk);
        dreq <= 1'b0;
        axi_rd(sgc_pkg::ADDR_STATUS, {1'b1, 1'b0, sel, 5'h05},
               sgc_pkg::RESP_OKAY);
        buf_done <= 1'b1;
        @(posedge aclk);
        buf_done <= 1'b0;
        axi_rd(sgc_pkg::ADDR_STATUS, {1'b1, 1'b0, sel, 5'h01},
               sgc_pkg::RESP_OKAY);
        // restart clears buffers and null, then termination indicator
        axi_wr(sgc_pkg::ADDR_CMD, 8'hC1, sgc_pkg::RESP_OKAY);
        sel = 1'b1;
        axi_rd(sgc_pkg::ADDR_STATUS, 8'h21, sgc_pkg::RESP_OKAY);
        tc_check(1'b1);
        axi_wr(sgc_pkg::ADDR_CMD, 8'h41, sgc_pkg::RESP_OKAY);
        sel = 1'b0;
        tc_check(1'b0);
        // interrupt masking and clearing
        axi_wr(sgc_pkg::ADDR_EVT_EN, 8'h00, sgc_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("irq masked", 32'h0, {31'h0, irq_ff});
        axi_rd(sgc_pkg::ADDR_EVT_STAT, 8'h05, sgc_pkg::RESP_OKAY);
        axi_wr(sgc_pkg::ADDR_EVT_EN, 8'h07, sgc_pkg::RESP_OKAY);
        axi_wr(sgc_pkg::ADDR_EVT_CLR, 8'h07, sgc_pkg::RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk("irq cleared", 32'h0, {31'h0, irq_ff});
        axi_rd(sgc_pkg::ADDR_EVT_STAT, 8'h00, sgc_pkg::RESP_OKAY);
        // stop during the first prefetch
        axi_wr(sgc_pkg::ADDR_CMD, 8'h01, sgc_pkg::RESP_OKAY);
        axi_wr(sgc_pkg::ADDR_CMD, 8'h02, sgc_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("chan_mask", 32'h1, {31'h0, chan_mask_ff});
        chk("sg_halt", 32'h1, {31'h0, sg_halt_ff});
        axi_rd(sgc_pkg::ADDR_STATUS, 8'h10, sgc_pkg::RESP_OKAY);
        axi_rd(sgc_pkg::ADDR_EVT_STAT, 8'h03, sgc_pkg::RESP_OKAY);
        mask_clr <= 1'b1;
        @(posedge aclk);
        mask_clr <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("mask_clr", 32'h0, {31'h0, chan_mask_ff});
        // master clear restores reset selection and unmasks
        axi_wr(sgc_pkg::ADDR_CMD, 8'hC2, sgc_pkg::RESP_OKAY);
        axi_rd(sgc_pkg::ADDR_STATUS, 8'h30, sgc_pkg::RESP_OKAY);
        axi_wr(sgc_pkg::ADDR_CTRL, 8'h01, sgc_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk("mclr mask", 32'h0, {31'h0, chan_mask_ff});
        axi_rd(sgc_pkg::ADDR_STATUS, 8'h00, sgc_pkg::RESP_OKAY);
        repeat (4) @(posedge aclk);
        finish_test();
    end
endmodule : sg_command_decoder_test
`default_nettype wire
